// >>> rtl/lec_classifier.sv
// Link error classifier: sorts link events into fatal, correctable and
// uncorrectable classes, keeps sticky status, sends error messages,
// watches acknowledgements and completions, and gates config readiness.
// Assumes all inputs come from logic on the same clock.
//
// Notes on behaviour
// [R1] A detected fatal condition sets device status bit 2.
// [R2] Error messages go upstream only when reporting is enabled in control.
// [R3] Training, link protocol, flow control, malformed, overflow errors are fatal.
// [R4] Receiver error, bad packet, bad link packet, replay timeout, rollover: correctable.
// [R5] Receiver detects the first three; transmitter raises replay conditions.
// [R6] Missing acknowledgement within the allowed time causes a resend.
// [R7] Poisoned, CRC, unsupported, timeout, abort, unexpected, access: uncorrectable.
// [R8] A request outside the allocated address window is unsupported.
// [R9] A request with no completion in time reports a completion timeout.
// [R10] Errors from the device's own transmitted traffic are not recorded in status.
// [R11] Link comes up and configuration requests are accepted during enumeration.
// [R12] The root issues configuration transactions while walking the hierarchy.
// [R13] A detailed per-error status vector identifies each flagged error.
// [R14] Detect state entered within 20 ms of reset release.
// [R15] Configuration requests accepted within 100 ms of reset release.
// [R16] Status bits stay set until cleared by writing one.
`timescale 1ns/1ps
module lec_classifier #(
  parameter int CPL_TO_CYC = lec_pkg::CPL_TO_CYC
) (
  input  wire logic        clock,
  input  wire logic        rst_n,
  input  wire logic        rx_training_err,
  input  wire logic        rx_dll_err,
  input  wire logic        rx_fc_err,
  input  wire logic        rx_malformed,
  input  wire logic        rx_overflow,
  input  wire logic        rx_recv_err,
  input  wire logic        rx_bad_tlp,
  input  wire logic        rx_bad_dllp,
  input  wire logic        rx_poisoned,
  input  wire logic        rx_ecrc_fail,
  input  wire logic        rx_cpl_abort,
  input  wire logic        rx_unexp_cpl,
  input  wire logic        rx_acs_viol,
  input  wire logic        evt_from_tx,
  input  wire logic        req_valid,
  input  wire logic [31:0] req_addr,
  input  wire logic [31:0] bar_base,
  input  wire logic [31:0] bar_mask,
  input  wire logic        tx_pkt_sent,
  input  wire logic        ack_rcvd,
  input  wire logic        np_req_sent,
  input  wire logic        cpl_rcvd,
  input  wire logic [3:0]  dev_ctl,
  input  wire logic [3:0]  sta_clr,
  input  wire logic [16:0] detail_clr,
  input  wire logic        link_up,
  input  wire logic        cfg_req,
  output logic [3:0]       dev_sta_r,
  output logic [16:0]      err_detail_r,
  output logic             msg_valid_r,
  output logic [1:0]       msg_type_r,
  output logic             replay_req_r,
  output logic             detect_r,
  output logic             cfg_ready_r,
  output logic             cfg_ack_r
);

  // ----------------------------------------------------------------
  // Acknowledgement and completion watchdogs
  // ----------------------------------------------------------------
  logic       ack_run;
  logic       ack_expire;
  logic       cpl_expire;
  logic [2:0] replay_cnt_r;
  logic       replay_roll;

  lec_timer u_ack_tmr (
    .clock   (clock),
    .rst_n   (rst_n),
    .start   (tx_pkt_sent || ack_expire),
    .stop    (ack_rcvd),
    .limit   (lec_pkg::REPLAY_TO_CYC),
    .running (ack_run),
    .expire  (ack_expire)
  );

  lec_timer u_cpl_tmr (
    .clock   (clock),
    .rst_n   (rst_n),
    .start   (np_req_sent),
    .stop    (cpl_rcvd),
    .limit   (CPL_TO_CYC),
    .running (),
    .expire  (cpl_expire)
  );

  assign replay_roll = ack_expire && (replay_cnt_r == lec_pkg::REPLAY_ROLL - 3'h1);  // R5

  always_ff @(posedge clock) begin
    if (!rst_n) begin
      replay_cnt_r <= 3'h0;
      replay_req_r <= 1'b0;
    end else begin
      replay_req_r <= ack_expire;  // R6
      if (ack_rcvd || tx_pkt_sent || replay_roll) replay_cnt_r <= 3'h0;
      else if (ack_expire) replay_cnt_r <= replay_cnt_r + 3'h1;
    end
  end

  // ----------------------------------------------------------------
  // Event gathering and classification
  // ----------------------------------------------------------------
  logic        addr_miss;
  logic [16:0] evt;
  logic [16:0] evt_rec;
  logic        any_fatal;
  logic        any_corr;
  logic        any_nonf;
  logic        any_ur;

  assign addr_miss = req_valid && ((req_addr & bar_mask) != (bar_base & bar_mask));  // R8

  assign evt[lec_pkg::EV_TRAINING]    = rx_training_err;  // R3
  assign evt[lec_pkg::EV_DLL_PROTO]   = rx_dll_err;
  assign evt[lec_pkg::EV_FC_PROTO]    = rx_fc_err;
  assign evt[lec_pkg::EV_MALFORMED]   = rx_malformed;
  assign evt[lec_pkg::EV_RX_OVERFLOW] = rx_overflow;
  assign evt[lec_pkg::EV_RX_ERR]      = rx_recv_err;  // R5
  assign evt[lec_pkg::EV_BAD_TLP]     = rx_bad_tlp;
  assign evt[lec_pkg::EV_BAD_DLLP]    = rx_bad_dllp;
  assign evt[lec_pkg::EV_REPLAY_TO]   = ack_expire;
  assign evt[lec_pkg::EV_REPLAY_ROLL] = replay_roll;
  assign evt[lec_pkg::EV_POISONED]    = rx_poisoned;  // R7
  assign evt[lec_pkg::EV_ECRC]        = rx_ecrc_fail;
  assign evt[lec_pkg::EV_UNSUP_REQ]   = addr_miss;
  assign evt[lec_pkg::EV_CPL_TIMEOUT] = cpl_expire;  // R9
  assign evt[lec_pkg::EV_CPL_ABORT]   = rx_cpl_abort;
  assign evt[lec_pkg::EV_UNEXP_CPL]   = rx_unexp_cpl;
  assign evt[lec_pkg::EV_ACS_VIOL]    = rx_acs_viol;

  // Own-transmit traffic never reaches the status bits
  assign evt_rec   = evt & {17{~evt_from_tx}};  // R10
  assign any_fatal = |(evt_rec & lec_pkg::FATAL_MASK);  // R3
  assign any_corr  = |(evt_rec & lec_pkg::CORR_MASK);  // R4
  assign any_nonf  = |(evt_rec & lec_pkg::NONF_MASK);  // R7
  assign any_ur    = evt_rec[lec_pkg::EV_UNSUP_REQ];

  // ----------------------------------------------------------------
  // Sticky status, set wins over clear
  // ----------------------------------------------------------------
  logic [3:0]  sta_set;
  logic [3:0]  dev_sta_nxt;
  logic [16:0] detail_nxt;

  assign sta_set[lec_pkg::STA_CORR]     = any_corr;
  assign sta_set[lec_pkg::STA_NONFATAL] = any_nonf;
  assign sta_set[lec_pkg::STA_FATAL]    = any_fatal;  // R1
  assign sta_set[lec_pkg::STA_UNSUP]    = any_ur;
  assign dev_sta_nxt = (dev_sta_r & ~sta_clr) | sta_set;  // R16
  assign detail_nxt  = (err_detail_r & ~detail_clr) | evt_rec;  // R13

  always_ff @(posedge clock) begin
    if (!rst_n) begin
      dev_sta_r    <= 4'h0;
      err_detail_r <= 17'h0;
    end else begin
      dev_sta_r    <= dev_sta_nxt;
      err_detail_r <= detail_nxt;
    end
  end

  // ----------------------------------------------------------------
  // Upstream error messages, most severe class first
  // ----------------------------------------------------------------
  logic       send_fatal;
  logic       send_nonf;
  logic       send_corr;
  logic       msg_nxt;
  logic [1:0] msg_type_nxt;

  assign send_fatal = any_fatal && dev_ctl[lec_pkg::CTL_FATAL_EN];  // R2
  assign send_nonf  = any_nonf && (any_ur ? dev_ctl[lec_pkg::CTL_UR_EN]
                                          : dev_ctl[lec_pkg::CTL_NONF_EN]);
  assign send_corr  = any_corr && dev_ctl[lec_pkg::CTL_CORR_EN];
  assign msg_nxt    = send_fatal || send_nonf || send_corr;
  assign msg_type_nxt = send_fatal ? lec_pkg::MSG_FATAL :
                        send_nonf  ? lec_pkg::MSG_NONFATAL : lec_pkg::MSG_CORR;

  always_ff @(posedge clock) begin
    if (!rst_n) begin
      msg_valid_r <= 1'b0;
      msg_type_r  <= lec_pkg::MSG_CORR;
    end else begin
      msg_valid_r <= msg_nxt;
      msg_type_r  <= msg_nxt ? msg_type_nxt : msg_type_r;
    end
  end

  // ----------------------------------------------------------------
  // Link bring-up and configuration readiness
  // ----------------------------------------------------------------
  lec_pkg::lec_link_e lnk_r;
  lec_pkg::lec_link_e lnk_nxt;

  always_comb begin
    case (lnk_r)
      lec_pkg::LNK_RESET:  lnk_nxt = lec_pkg::LNK_DETECT;  // R14
      lec_pkg::LNK_DETECT: lnk_nxt = link_up ? lec_pkg::LNK_ACTIVE : lec_pkg::LNK_DETECT;
      lec_pkg::LNK_ACTIVE: lnk_nxt = link_up ? lec_pkg::LNK_ACTIVE : lec_pkg::LNK_DETECT;
      default:             lnk_nxt = lec_pkg::LNK_RESET;
    endcase
  end

  always_ff @(posedge clock) begin
    if (!rst_n) begin
      lnk_r       <= lec_pkg::LNK_RESET;
      detect_r    <= 1'b0;
      cfg_ready_r <= 1'b0;
      cfg_ack_r   <= 1'b0;
    end else begin
      lnk_r       <= lnk_nxt;
      detect_r    <= (lnk_nxt == lec_pkg::LNK_DETECT);  // R14
      cfg_ready_r <= (lnk_nxt == lec_pkg::LNK_ACTIVE);  // R15
      cfg_ack_r   <= cfg_req && (lnk_r == lec_pkg::LNK_ACTIVE);  // R11
    end
  end

endmodule

// >>> rtl/lec_pkg.sv
// Constants for the link error classifier: event indices, class masks,
// status layout, message codes and timing counts. No surroundings assumed.
package lec_pkg;

  // ----------------------------------------------------------------
  // Clock and timing
  // ----------------------------------------------------------------
  localparam int CLK_PERIOD_NS   = 10;
  localparam int DETECT_MAX_MS   = 20;
  localparam int CFG_READY_MS    = 100;
  localparam int REPLAY_TO_NS    = 10000;
  localparam int CPL_TO_MS       = 50;
  localparam int REPLAY_TO_CYC   = REPLAY_TO_NS / CLK_PERIOD_NS;
  localparam int CPL_TO_CYC      = (CPL_TO_MS * 1000000) / CLK_PERIOD_NS;
  localparam int DETECT_MAX_CYC  = (DETECT_MAX_MS * 1000000) / CLK_PERIOD_NS;
  localparam int CFG_READY_CYC   = (CFG_READY_MS * 1000000) / CLK_PERIOD_NS;
  localparam logic [2:0] REPLAY_ROLL = 3'h4;

  // ----------------------------------------------------------------
  // Error event indices
  // ----------------------------------------------------------------
  localparam int NUM_EVT         = 17;
  localparam int EV_TRAINING     = 0;
  localparam int EV_DLL_PROTO    = 1;
  localparam int EV_FC_PROTO     = 2;
  localparam int EV_MALFORMED    = 3;
  localparam int EV_RX_OVERFLOW  = 4;
  localparam int EV_RX_ERR       = 5;
  localparam int EV_BAD_TLP      = 6;
  localparam int EV_BAD_DLLP     = 7;
  localparam int EV_REPLAY_TO    = 8;
  localparam int EV_REPLAY_ROLL  = 9;
  localparam int EV_POISONED     = 10;
  localparam int EV_ECRC         = 11;
  localparam int EV_UNSUP_REQ    = 12;
  localparam int EV_CPL_TIMEOUT  = 13;
  localparam int EV_CPL_ABORT    = 14;
  localparam int EV_UNEXP_CPL    = 15;
  localparam int EV_ACS_VIOL     = 16;

  localparam logic [16:0] FATAL_MASK = 17'h0001f;
  localparam logic [16:0] CORR_MASK  = 17'h003e0;
  localparam logic [16:0] NONF_MASK  = 17'h1fc00;

  // ----------------------------------------------------------------
  // Device status and control layout
  // ----------------------------------------------------------------
  localparam int STA_CORR        = 0;
  localparam int STA_NONFATAL    = 1;
  localparam int STA_FATAL       = 2;
  localparam int STA_UNSUP       = 3;
  localparam int CTL_CORR_EN     = 0;
  localparam int CTL_NONF_EN     = 1;
  localparam int CTL_FATAL_EN    = 2;
  localparam int CTL_UR_EN       = 3;

  localparam logic [1:0] MSG_CORR     = 2'h0;
  localparam logic [1:0] MSG_NONFATAL = 2'h1;
  localparam logic [1:0] MSG_FATAL    = 2'h3;

  typedef enum logic [2:0] {
    LNK_RESET  = 3'h1,
    LNK_DETECT = 3'h2,
    LNK_ACTIVE = 3'h4
  } lec_link_e;

  typedef enum logic [1:0] {
    TMR_IDLE = 2'h1,
    TMR_RUN  = 2'h2
  } lec_tmr_e;

endpackage

// >>> rtl/lec_timer.sv
// Restartable watchdog: runs from start until stop or limit cycles pass.
// Assumes start and stop are single-cycle pulses on the same clock.
`timescale 1ns/1ps
module lec_timer (
  input  wire logic        clock,
  input  wire logic        rst_n,
  input  wire logic        start,
  input  wire logic        stop,
  input  wire logic [31:0] limit,
  output logic             running,
  output logic             expire
);

  lec_pkg::lec_tmr_e state_r;
  lec_pkg::lec_tmr_e state_nxt;
  logic [31:0]       cnt_r;
  logic              hit;

  assign hit     = (state_r == lec_pkg::TMR_RUN) && (cnt_r == limit - 32'h1);
  assign running = (state_r == lec_pkg::TMR_RUN);

  always_comb begin
    case (state_r)
      lec_pkg::TMR_IDLE: state_nxt = start ? lec_pkg::TMR_RUN : lec_pkg::TMR_IDLE;
      lec_pkg::TMR_RUN: begin
        if (start) state_nxt = lec_pkg::TMR_RUN;
        else if (stop || hit) state_nxt = lec_pkg::TMR_IDLE;
        else state_nxt = lec_pkg::TMR_RUN;
      end
      default: state_nxt = lec_pkg::TMR_IDLE;
    endcase
  end

  always_ff @(posedge clock) begin
    if (!rst_n) begin
      state_r <= lec_pkg::TMR_IDLE;
      cnt_r   <= 32'h0;
      expire  <= 1'b0;
    end else begin
      state_r <= state_nxt;
      cnt_r   <= (start || state_r != lec_pkg::TMR_RUN) ? 32'h0 : cnt_r + 32'h1;
      expire  <= hit && !stop && !start;
    end
  end

endmodule

// >>> verif/lec_classifier_props.sv
// Assertion checker for the link error classifier top ports.
// Assumes one clock domain and a synchronous active-low reset.
`timescale 1ns/1ps
module lec_classifier_props (
  input wire logic        clock,
  input wire logic        rst_n,
  input wire logic        rx_malformed,
  input wire logic        rx_bad_tlp,
  input wire logic        rx_poisoned,
  input wire logic        evt_from_tx,
  input wire logic        req_valid,
  input wire logic [31:0] req_addr,
  input wire logic [31:0] bar_base,
  input wire logic [31:0] bar_mask,
  input wire logic        tx_pkt_sent,
  input wire logic [3:0]  dev_ctl,
  input wire logic [3:0]  sta_clr,
  input wire logic        cfg_req,
  input wire logic [3:0]  dev_sta_r,
  input wire logic [16:0] err_detail_r,
  input wire logic        msg_valid_r,
  input wire logic [1:0]  msg_type_r,
  input wire logic        replay_req_r,
  input wire logic        detect_r,
  input wire logic        cfg_ready_r,
  input wire logic        cfg_ack_r
);
  // ----------------------------------------------------------------
  // Helpers and properties
  // ----------------------------------------------------------------
  default clocking cb @(posedge clock); endclocking
  default disable iff (!rst_n);
  int unsigned since_r;
  always_ff @(posedge clock) begin
    if (!rst_n || tx_pkt_sent) begin
      since_r <= 0;
    end else if (since_r < 2000) begin
      since_r <= since_r + 1;
    end
  end
  sequence s_fatal;
    rx_malformed && !evt_from_tx;
  endsequence
  sequence s_miss;
    req_valid && !evt_from_tx && (((req_addr ^ bar_base) & bar_mask) != 32'h0);
  endsequence
  a_fatal_class: assert property (s_fatal |=> dev_sta_r[2] && err_detail_r[3])
    else $error("fatal event did not set status");
  a_corr_class: assert property (rx_bad_tlp && !evt_from_tx |=> dev_sta_r[0])
    else $error("correctable event did not set status");
  a_nonf_class: assert property (rx_poisoned && !evt_from_tx |=> dev_sta_r[1])
    else $error("nonfatal event did not set status");
  a_fatal_msg: assert property (s_fatal ##0 dev_ctl[2] |=> msg_valid_r && msg_type_r == 2'h3)
    else $error("fatal message missing");
  a_corr_gate: assert property (msg_valid_r && msg_type_r == 2'h0 |-> $past(dev_ctl[0]))
    else $error("correctable message while disabled");
  a_sta_sticky: assert property (dev_sta_r[2] && !sta_clr[2] |=> dev_sta_r[2])
    else $error("fatal status lost without clear");
  a_ur_window: assert property (s_miss |=> dev_sta_r[3] && dev_sta_r[1] && err_detail_r[12])
    else $error("window miss not flagged");
  a_replay_early: assert property (replay_req_r |-> since_r >= 999)
    else $error("resend too early");
  a_cfg_ack: assert property (cfg_req |=> cfg_ack_r == $past(cfg_ready_r))
    else $error("config accept wrong");
  a_detect_soon: assert property ($rose(rst_n) |-> ##[1:2] (detect_r || cfg_ready_r))
    else $error("detect state late");
endmodule
bind lec_classifier lec_classifier_props u_props (.*);

// >>> verif/lec_link_partner.sv
// Link partner model: acknowledges packets and returns completions.
// A delay of zero means the partner stays silent.
`timescale 1ns/1ps
module lec_link_partner (
  input  wire logic        clock,
  input  wire logic        rst_n,
  input  wire logic        tx_pkt_sent,
  input  wire logic        np_req_sent,
  input  wire logic [15:0] ack_dly,
  input  wire logic [15:0] cpl_dly,
  output logic             ack_rcvd = 1'b0,
  output logic             cpl_rcvd = 1'b0
);
  int a_cnt = 0;
  int c_cnt = 0;
  always @(posedge clock) begin
    ack_rcvd <= rst_n && a_cnt == 1;
    cpl_rcvd <= rst_n && c_cnt == 1;
    a_cnt <= !rst_n ? 0 : tx_pkt_sent ? int'(ack_dly) : (a_cnt > 0 ? a_cnt - 1 : 0);
    c_cnt <= !rst_n ? 0 : np_req_sent ? int'(cpl_dly) : (c_cnt > 0 ? c_cnt - 1 : 0);
  end
endmodule

// >>> verif/lec_classifier_tb_top.sv
// Testbench for the link error classifier: classes, gating, window check,
// watchdogs and config readiness. Assumes lec_link_partner on the far side.
`timescale 1ns/1ps
module lec_classifier_tb_top;
  localparam int CPL = 64;
  logic clock = 1'b0, rst_n = 1'b0, evt_from_tx = 1'b0, req_valid = 1'b0;
  logic tx_pkt_sent = 1'b0, np_req_sent = 1'b0, link_up = 1'b0, cfg_req = 1'b0;
  logic [16:0] ev = '0, detail_clr = '0, err_detail_r;
  logic [31:0] req_addr = '0, bar_base = '0, bar_mask = '0, b;
  logic [3:0]  dev_ctl = '0, sta_clr = '0, dev_sta_r;
  logic [15:0] ack_dly = '0, cpl_dly = '0;
  logic        ack_rcvd, cpl_rcvd, msg_valid_r, replay_req_r, detect_r, cfg_ready_r, cfg_ack_r;
  logic [1:0]  msg_type_r;
  logic [1:0]  exp_q[$];
  int          errors = 0, checks = 0, cyc = 0, acks = 0, n;
  lec_classifier #(.CPL_TO_CYC(CPL)) u_dut (.*,
    .rx_training_err(ev[0]), .rx_dll_err(ev[1]), .rx_fc_err(ev[2]),
    .rx_malformed(ev[3]), .rx_overflow(ev[4]), .rx_recv_err(ev[5]),
    .rx_bad_tlp(ev[6]), .rx_bad_dllp(ev[7]), .rx_poisoned(ev[10]),
    .rx_ecrc_fail(ev[11]), .rx_cpl_abort(ev[14]), .rx_unexp_cpl(ev[15]),
    .rx_acs_viol(ev[16]));
  lec_link_partner u_partner (.*);
  initial begin
    forever #5 clock = ~clock;
  end
  task automatic end_of_test();
    $display("errors %0d checks %0d", errors, checks);
    if (errors == 0 && checks > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks++;
    if (got !== exp) begin
      errors++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic chk_msg(input logic [1:0] exp, input logic [1:0] got);
    checks++;
    if (got !== exp) begin
      errors++;
      $display("mismatch at %0t: message %h expected %h", $time, got, exp);
    end
  endtask
  task automatic tick(input int k);
    repeat (k) @(posedge clock);
    #1;
  endtask
  // Drives one cycle of stimulus, then returns it to idle
  task automatic pulse(input logic [16:0] v, input logic t, input logic [31:0] a, input int k);
    @(posedge clock);
    ev <= v;
    evt_from_tx <= t;
    req_valid <= k == 1;
    req_addr <= a;
    tx_pkt_sent <= k == 2;
    np_req_sent <= k == 3;
    cfg_req <= k == 4;
    @(posedge clock);
    {ev, evt_from_tx, req_valid, tx_pkt_sent, np_req_sent, cfg_req} <= '0;
    #1;
  endtask
  task automatic clr();
    @(posedge clock);
    sta_clr <= 4'hf;
    detail_clr <= '1;
    @(posedge clock);
    sta_clr <= '0;
    detail_clr <= '0;
    tick(1);
    chk({dev_sta_r, err_detail_r}, '0);
  endtask
  // ----------------------------------------------------------------
  // Result watcher
  // ----------------------------------------------------------------
  always @(negedge clock) begin
    cyc++;
    if (cfg_ack_r === 1'b1) acks++;
    // Code 2 is never sent, so an unplanned message always mismatches
    if (msg_valid_r === 1'b1) chk_msg(exp_q.size() > 0 ? exp_q.pop_front() : 2'h2, msg_type_r);
    if (cyc == 30000) begin
      errors++;
      end_of_test();
    end
  end
  initial begin
    void'($urandom(32'hd969));
    tick(20);
    chk({dev_sta_r, err_detail_r, msg_valid_r, replay_req_r, detect_r, cfg_ack_r}, '0);
    @(posedge clock) rst_n <= 1'b1;
    tick(3);
    chk(detect_r, 1'b1);
    @(posedge clock) dev_ctl <= 4'hf;
    for (int i = 0; i < 17; i++) begin
      if (i inside {8, 9, 12, 13}) continue;
      exp_q.push_back(i < 5 ? 2'h3 : i < 10 ? 2'h0 : 2'h1);
      pulse(17'h1 << i, 1'b0, 32'h0, 0);
      tick(3);
      chk(err_detail_r, 17'h1 << i);
      chk(dev_sta_r, i < 5 ? 4'h4 : i < 10 ? 4'h1 : 4'h2);
      clr();
    end
    exp_q.push_back(2'h3);
    pulse(17'h428, 1'b0, 32'h0, 0);
    chk(dev_sta_r, 4'h7);
    clr();
    pulse(17'h428, 1'b1, 32'h0, 0);
    chk({dev_sta_r, err_detail_r}, '0);
    @(posedge clock) dev_ctl <= 4'h0;
    pulse(17'h428, 1'b0, 32'h0, 0);
    chk(dev_sta_r, 4'h7);
    clr();
    b = $urandom & 32'hfffff000;
    @(posedge clock) bar_base <= b;
    @(posedge clock) bar_mask <= 32'hfffff000;
    @(posedge clock) dev_ctl <= 4'h8;
    pulse('0, 1'b0, b | ($urandom & 32'hfff), 1);
    chk(dev_sta_r, 4'h0);
    exp_q.push_back(2'h1);
    pulse('0, 1'b0, b ^ 32'h1000, 1);
    chk({dev_sta_r, err_detail_r}, {4'ha, 17'h1000});
    clr();
    @(posedge clock) dev_ctl <= 4'h2;
    pulse('0, 1'b0, b ^ 32'h80000000, 1);
    chk(dev_sta_r, 4'ha);
    clr();
    @(posedge clock) dev_ctl <= 4'h0;
    ack_dly = 16'd5;
    pulse('0, 1'b0, 32'h0, 2);
    tick(1100);
    chk(err_detail_r, '0);
    ack_dly = 16'd0;
    pulse('0, 1'b0, 32'h0, 2);
    n = 0;
    while (replay_req_r !== 1'b1 && n < 2000) begin
      tick(1);
      n++;
    end
    chk(n, 1001);
    chk({dev_sta_r[0], err_detail_r[8]}, 2'h3);
    tick(3003);
    chk(err_detail_r[9], 1'b1);
    ack_dly = 16'd5;
    pulse('0, 1'b0, 32'h0, 2);
    clr();
    tick(1100);
    chk(err_detail_r, '0);
    cpl_dly = 16'd10;
    pulse('0, 1'b0, 32'h0, 3);
    tick(CPL + 10);
    chk(err_detail_r[13], 1'b0);
    cpl_dly = 16'd0;
    pulse('0, 1'b0, 32'h0, 3);
    tick(CPL - 4);
    chk(err_detail_r[13], 1'b0);
    tick(8);
    chk({dev_sta_r[1], err_detail_r[13]}, 2'h3);
    pulse('0, 1'b0, 32'h0, 4);
    tick(2);
    chk(acks, 0);
    @(posedge clock) link_up <= 1'b1;
    tick(3);
    chk(cfg_ready_r, 1'b1);
    for (int i = 0; i < 3; i++) pulse('0, 1'b0, 32'h0, 4);
    tick(2);
    chk(acks, 3);
    @(posedge clock) rst_n <= 1'b0;
    @(posedge clock) link_up <= 1'b0;
    tick(3);
    chk({dev_sta_r, err_detail_r, cfg_ready_r, detect_r}, '0);
    @(posedge clock) rst_n <= 1'b1;
    tick(3);
    chk(detect_r, 1'b1);
    chk(exp_q.size(), 0);
    end_of_test();
  end
endmodule
